// file: core/eeprom_pkg.sv
// Purpose: shared constants for the serial eeprom protect-control block
// Assumes: 50 MHz system clock, serial link sampled by that clock
// Notes: array is 128 words of 16 bits; boundary register is 8 bits
package eeprom_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int BOUND_W = 8;
    localparam int WORDS = 128;
    // frame field widths
    localparam int OP_W = 2;
    localparam int AFIELD_W = 8;
    localparam int HDR_BITS = 1 + OP_W + AFIELD_W;
    localparam int FRAME_BITS = HDR_BITS + DATA_W;
    // opcodes
    localparam logic [1:0] OP_CTRL = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;
    // top two address bits for control opcode
    localparam logic [1:0] TOP_UNLOCK = 2'h3;
    localparam logic [1:0] TOP_FILL = 2'h1;
    localparam logic [1:0] TOP_LOCK = 2'h0;
    localparam logic [7:0] FREEZE_ADDR = 8'h00;
    localparam logic [7:0] CLEAR_ADDR = 8'hFF;
    // boundary reset value: all ones
    localparam logic [7:0] BOUND_CLEARED = 8'hFF;
    localparam logic [7:0] BOUND_RESET = 8'hFF;
    // programming time
    localparam int CLK_MHZ = 50;
    localparam int PROG_TIME_US = 10;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_WRITE, CMD_FILL, CMD_BRESET, CMD_BSET, CMD_BFREEZE
    } prog_t;
endpackage

// file: core/word_buf_if.sv
// Purpose: valid/ready carrier between the frame receiver and the executor
// Assumes: single clock domain
// Notes: carries one decoded frame
`timescale 1ns/1ns
interface word_buf_if;
    logic valid;
    logic ready;
    logic [1:0] op;
    logic [7:0] addr;
    logic [15:0] data;
    logic bSel;
    logic pEn;
    modport src (output valid, op, addr, data, bSel, pEn, input ready);
    modport snk (input valid, op, addr, data, bSel, pEn, output ready);
endinterface

// file: core/frame_skid.sv
// Purpose: two-entry buffer for decoded frames
// Assumes: same clock on both sides
// Notes: a stall by the executor loses no frame; inReady drops when full
`timescale 1ns/1ns
module frame_skid #(
    parameter int W = 28
) (
    input wire logic sys_clk, // system clock
    input wire logic arst_n, // async reset
    input wire logic inValid, // word offered
    output logic inReady, // room for a word
    input wire logic [W-1:0] inData, // word in
    output logic outValid, // word held
    input wire logic outReady, // drain takes head
    output logic [W-1:0] outData // head word
);
    logic [W-1:0] mem_r [2];
    logic rdPtr_r, wrPtr_r;
    logic [1:0] cnt_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    assign inReady = cnt_r != 2'h2;
    assign outValid = cnt_r != 2'h0;
    assign outData = mem_r[rdPtr_r];
    // storage and pointers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            rdPtr_r <= 1'b0;
            wrPtr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r <= ~wrPtr_r;
            end
            if (pop) rdPtr_r <= ~rdPtr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: core/eeprom_ctrl.sv
// Purpose: instruction execution and write protection of a serial eeprom
// Assumes: chip select, clock and data pins are asynchronous to sys_clk
// Notes: serial_clock must be slow enough for sys_clk to see each edge
// Summary of operation
// [RULE_01] start write-disabled; programming rejected until unlock
// [RULE_02] unlocked until lock command or reset
// [RULE_03] unlock takes effect at select fall
// [RULE_04] array reads ignore write-enable state
// [RULE_05] word write needs enable, unprotected, pins
// [RULE_06] select fall after data launches programming
// [RULE_07] busy for program time, new frames ignored
// [RULE_08] select high while busy shows status
// [RULE_09] status needs no serial clock edges
// [RULE_10] master waits for ready, then locks
// [RULE_11] fill-all needs cleared boundary, enable, pins
// [RULE_12] lock command clears enable at select fall
// [RULE_13] boundary read: dummy zero, eight bits msb
// [RULE_14] addresses at or above boundary protected
// [RULE_15] boundary unlock needs enable, both pins high
// [RULE_16] boundary unlock immediately precedes boundary command
// [RULE_17] boundary reset loads all ones, self-timed
// [RULE_18] boundary set needs prior reset and unlock
// [RULE_19] boundary freeze once, then boundary fixed
// [RULE_20] output released while select is low
// [RULE_21] select toggling never disturbs programming
// [RULE_22] start bit clears ready status display
// [RULE_23] frame: start, opcode, address, optional data
// [RULE_24] decode opcode, pins, top address bits
// [RULE_25] sample data on serial clock rising edge
// [RULE_26] program enable pin gates write operations
// [RULE_27] boundary arm lasts one instruction only
// [RULE_28] rejected command starts no cycle, ready
`timescale 1ns/1ns
module eeprom_ctrl #(
    parameter int PROG_CYC = eeprom_pkg::PROG_CYCLES
) (
    input wire logic sys_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic chip_select, // select pin
    input wire logic serial_clock, // link clock pin
    input wire logic serial_in, // data in pin
    output logic serial_out_o, // data out value
    output logic serial_out_oe_n, // data out enable, low drives
    input wire logic program_enable_pin, // write-type enable pin
    input wire logic protect_select_pin, // boundary select pin
    output logic busy // self-timed cycle running
);
    // synchronisers
    logic [1:0] csS_r, skS_r, diS_r, peS_r, psS_r;
    logic skD_r, csD_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            csS_r <= 2'h0;
            skS_r <= 2'h0;
            diS_r <= 2'h0;
            peS_r <= 2'h0;
            psS_r <= 2'h0;
            skD_r <= 1'b0;
            csD_r <= 1'b0;
        end else begin
            csS_r <= {csS_r[0], chip_select};
            skS_r <= {skS_r[0], serial_clock};
            diS_r <= {diS_r[0], serial_in};
            peS_r <= {peS_r[0], program_enable_pin};
            psS_r <= {psS_r[0], protect_select_pin};
            skD_r <= skS_r[1];
            csD_r <= csS_r[1];
        end
    end
    wire cs = csS_r[1];
    wire di = diS_r[1];
    wire skRise = skS_r[1] && !skD_r;
    wire csFall = csD_r && !cs;

    // frame receiver
    logic [4:0] bitCnt_r;
    logic started_r;
    logic [25:0] shift_r;
    logic pendFrame_r;
    logic statusShow_r;
    logic [16:0] outSh_r;
    logic reading_r;
    logic [7:0] bound_r;
    logic frozen_r;
    logic [$clog2(PROG_CYC+1)-1:0] progCnt_r;
    // header-only view: after eleven bits the opcode and address sit at the bottom
    wire [1:0] rxOp = shift_r[9:8];
    wire [7:0] rxAddr = shift_r[7:0];
    wire hdrDone = started_r && bitCnt_r == 5'(eeprom_pkg::HDR_BITS);
    wire readCmd = hdrDone && rxOp == eeprom_pkg::OP_READ;
    // sample on rising edges while selected; idle busy frames ignored
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCnt_r <= 5'h0;
            started_r <= 1'b0;
            shift_r <= '0;
        end else if (!cs || busy) begin // RULE_07
            bitCnt_r <= 5'h0;
            started_r <= 1'b0;
            shift_r <= '0;
        end else if (skRise) begin // RULE_25
            if (!started_r) begin
                if (di) begin // RULE_23
                    started_r <= 1'b1;
                    bitCnt_r <= 5'h1;
                    shift_r <= 26'h1;
                end
            end else if (bitCnt_r != 5'(eeprom_pkg::FRAME_BITS)) begin
                bitCnt_r <= bitCnt_r + 5'h1;
                shift_r <= {shift_r[24:0], di};
            end
        end
    end

    // frame packer into the buffer at select fall
    word_buf_if fb ();
    logic [27:0] packIn, packOut;
    logic packValid, packReady;
    wire fullData = bitCnt_r == 5'(eeprom_pkg::FRAME_BITS);
    // with data the start bit has been pushed out, opcode sits in the top two bits
    wire [1:0] fop = fullData ? shift_r[25:24] : shift_r[9:8];
    wire [7:0] fad = fullData ? shift_r[23:16] : shift_r[7:0];
    wire hdrOk = started_r && (bitCnt_r == 5'(eeprom_pkg::HDR_BITS) || fullData);
    assign packValid = csFall && hdrOk && !reading_r;
    assign packIn = {psS_r[1], peS_r[1], fop, fad, fullData ? shift_r[15:0] : 16'h0};
    // bit counter and shift register are cleared by select low the same edge
    frame_skid #(.W(28)) u_skid (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .inValid(packValid),
        .inReady(packReady),
        .inData(packIn),
        .outValid(fb.valid),
        .outReady(fb.ready),
        .outData(packOut)
    );
    assign {fb.bSel, fb.pEn, fb.op, fb.addr, fb.data} = packOut;
    assign fb.ready = !busy;

    // decode
    logic wen_r, armed_r, cleared_r;
    eeprom_pkg::prog_t pend;
    logic [1:0] top;
    logic take;
    assign top = fb.addr[7:6];
    assign take = fb.valid && fb.ready;
    always_comb begin // RULE_24
        pend = eeprom_pkg::CMD_NONE;
        if (!fb.pEn || !wen_r) begin // RULE_26
            pend = eeprom_pkg::CMD_NONE; // RULE_01
        end else if (!fb.bSel) begin
            if (fb.op == eeprom_pkg::OP_WRITE && {1'b0, fb.addr[6:0]} < bound_r) // RULE_14
                pend = eeprom_pkg::CMD_WRITE; // RULE_05
            else if (fb.op == eeprom_pkg::OP_CTRL && top == eeprom_pkg::TOP_FILL
                     && bound_r == eeprom_pkg::BOUND_CLEARED && cleared_r)
                pend = eeprom_pkg::CMD_FILL; // RULE_11
        end else if (armed_r && !frozen_r) begin // RULE_16
            if (fb.op == eeprom_pkg::OP_CLEAR && fb.addr == eeprom_pkg::CLEAR_ADDR)
                pend = eeprom_pkg::CMD_BRESET; // RULE_17
            else if (fb.op == eeprom_pkg::OP_WRITE && cleared_r)
                pend = eeprom_pkg::CMD_BSET; // RULE_18
            else if (fb.op == eeprom_pkg::OP_CTRL && fb.addr == eeprom_pkg::FREEZE_ADDR)
                pend = eeprom_pkg::CMD_BFREEZE; // RULE_19
        end
    end
    wire isUnlock = fb.op == eeprom_pkg::OP_CTRL && top == eeprom_pkg::TOP_UNLOCK;
    wire isLock = fb.op == eeprom_pkg::OP_CTRL && top == eeprom_pkg::TOP_LOCK && !fb.bSel;

    // write-enable latch and boundary arm
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wen_r <= 1'b0; // RULE_01
            armed_r <= 1'b0;
        end else if (take) begin
            if (isUnlock && !fb.bSel && fb.pEn) wen_r <= 1'b1; // RULE_03 RULE_02
            else if (isLock) wen_r <= 1'b0; // RULE_12
            armed_r <= isUnlock && fb.bSel && fb.pEn && wen_r; // RULE_15 RULE_27
        end
    end

    // array storage and self-timed cycle
    logic [15:0] mem_r [eeprom_pkg::WORDS];
    eeprom_pkg::prog_t job_r;
    logic [7:0] jobAddr_r;
    logic [15:0] jobData_r;
    assign busy = progCnt_r != '0;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            progCnt_r <= '0;
            job_r <= eeprom_pkg::CMD_NONE;
            jobAddr_r <= 8'h00;
            jobData_r <= 16'h0000;
        end else if (take && pend != eeprom_pkg::CMD_NONE) begin // RULE_28
            progCnt_r <= ($clog2(PROG_CYC+1))'(PROG_CYC); // RULE_06
            job_r <= pend;
            jobAddr_r <= fb.addr;
            jobData_r <= fb.data;
        end else if (busy) begin // RULE_21
            progCnt_r <= progCnt_r - 1'b1;
        end
    end
    wire jobEnd = progCnt_r == 1;
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
            if (jobEnd && (job_r == eeprom_pkg::CMD_FILL
                || (job_r == eeprom_pkg::CMD_WRITE && jobAddr_r[6:0] == 7'(i))))
                mem_r[i] <= jobData_r;
        end
    end
    // boundary register and freeze commit at end of the cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bound_r <= eeprom_pkg::BOUND_RESET;
            frozen_r <= 1'b0;
            cleared_r <= 1'b0;
        end else if (jobEnd) begin
            unique case (job_r)
                eeprom_pkg::CMD_BRESET: begin
                    bound_r <= eeprom_pkg::BOUND_CLEARED; // RULE_17
                    cleared_r <= 1'b1;
                end
                eeprom_pkg::CMD_BSET: bound_r <= {1'b0, jobAddr_r[6:0]}; // RULE_18
                eeprom_pkg::CMD_BFREEZE: frozen_r <= 1'b1; // RULE_19
                default: ;
            endcase
        end
    end

    // status display and read shifter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusShow_r <= 1'b0;
            pendFrame_r <= 1'b0;
        end else begin
            if (take && pend != eeprom_pkg::CMD_NONE) pendFrame_r <= 1'b1;
            if (pendFrame_r && cs && !csD_r) statusShow_r <= 1'b1; // RULE_08 RULE_09
            if (statusShow_r && !busy && skRise && di) begin // RULE_22
                statusShow_r <= 1'b0;
                pendFrame_r <= 1'b0;
            end else if (!busy && csFall && statusShow_r) begin
                statusShow_r <= 1'b0;
                pendFrame_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            outSh_r <= '0;
            reading_r <= 1'b0;
        end else if (!cs) begin
            reading_r <= 1'b0;
        end else if (readCmd && !reading_r) begin // RULE_04
            reading_r <= 1'b1;
            outSh_r <= psS_r[1] ? {1'b0, bound_r, 8'h00} // RULE_13
                                          : {1'b0, mem_r[rxAddr[6:0]]};
        end else if (reading_r && skRise) begin
            outSh_r <= {outSh_r[15:0], 1'b0};
        end
    end
    // status shows the counter directly, so it reflects the cycle without clocks
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_out_o <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            serial_out_oe_n <= !(cs && (statusShow_r || reading_r)); // RULE_20
            serial_out_o <= reading_r ? outSh_r[16] : !busy;
        end
    end

    // checks on the executor; all in the system clock domain
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // a frame accepted with a real job behind it
    sequence s_launch;
        take && pend != eeprom_pkg::CMD_NONE;
    endsequence
    // last cycle of a self-timed job
    sequence s_jobLast;
        progCnt_r == 1;
    endsequence
    // an accepted job loads the full program time at once
    a_cycle_start: assert property (s_launch |=> busy && progCnt_r == PROG_CYC) // RULE_06
        else $error("self-timed cycle did not start with full length");
    // the cycle ends after its last count, never runs on
    a_cycle_end: assert property (s_jobLast |=> !busy) // RULE_07
        else $error("busy did not end after the last count");
    // while busy the receiver is held empty, so no frame is collected
    a_busy_refuse: assert property (busy |=> !started_r) // RULE_07
        else $error("frame collected while busy");
    // write-disabled device never starts a job
    a_locked_idle: assert property (!wen_r && !busy |=> !busy) // RULE_01
        else $error("job started while write-disabled");
    // released data line whenever select is low
    a_out_released: assert property (!cs |=> serial_out_oe_n) // RULE_20
        else $error("data out driven while deselected");
    // status value is low while the job runs
    a_status_busy: assert property (!reading_r && busy |=> !serial_out_o) // RULE_08
        else $error("status shows ready while busy");
    // boundary arm survives only into the very next instruction
    a_arm_oneshot: assert property (take && !isUnlock |=> !armed_r) // RULE_27
        else $error("boundary arm outlived the next instruction");
    // once frozen the boundary never moves again
    a_bound_frozen: assert property (frozen_r |=> $stable(bound_r)) // RULE_19
        else $error("boundary changed after freeze");
endmodule

// file: tb/link_master.sv
// Purpose: behavioural serial bus master driving the eeprom select, clock and data pins
// Assumes: tasks are entered just after a falling sys_clk edge; link clock period 160 ns, 240 ns for read data bits
// Notes: link clock stands still outside frames; data in is inverted once released
`timescale 1ns/1ns
module link_master (
    output logic chip_select, // select pin
    output logic serial_clock, // link clock
    output logic serial_in, // data towards the device
    output logic program_enable_pin, // write-type enable
    output logic protect_select_pin, // boundary select
    input wire logic serial_out // data from the device
);
    // idle pins at time zero
    initial begin
        chip_select = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b1;
        program_enable_pin = 1'b0;
        protect_select_pin = 1'b0;
    end
    // released data line shows the inverse so a stale level never passes as valid
    task automatic select(input logic v);
        chip_select = v;
        if (!v) serial_in = ~serial_in;
    endtask
    // bits go out msb first, changed while the clock is low
    task automatic shift(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            #80 serial_clock = 1'b1;
            #80 serial_clock = 1'b0;
        end
    endtask
    // start, opcode, address, optional data; select drops before any further clock rise
    task automatic frame(input logic pre, input logic pe, input logic [10:0] hdr,
                         input logic hasData, input logic [15:0] data);
        protect_select_pin = pre;
        program_enable_pin = pe;
        select(1'b1);
        #80;
        shift({5'h00, hdr}, 11);
        if (hasData) shift(data, 16);
        select(1'b0);
        #80;
    endtask
    // header then dummy bit and n data bits, each sampled halfway through the low phase
    task automatic read(input logic pre, input logic [10:0] hdr, input int n,
                        output logic [16:0] v);
        v = 17'h00000;
        protect_select_pin = pre;
        program_enable_pin = 1'b0;
        select(1'b1);
        #80;
        shift({5'h00, hdr}, 11);
        #80 v[n] = serial_out;
        for (int i = n - 1; i >= 0; i--) begin
            #80 serial_clock = 1'b1;
            #80 serial_clock = 1'b0;
            #80 v[i] = serial_out;
        end
        select(1'b0);
        #80;
    endtask
endmodule

// file: tb/serial_eeprom_write_protect_control_bench.sv
// Purpose: self-checking bench for the eeprom instruction and protect logic
// Assumes: programming time shortened to 300 cycles
// Notes: frames follow each other in the order the rows give; busy length is counted
`timescale 1ns/1ns
module serial_eeprom_write_protect_control_bench;
    localparam int PROG = 300;
    typedef struct packed {
        logic pre; logic pe; logic [10:0] hdr; logic hasData; logic [15:0] data; logic start;
    } row_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic chipSel, linkClk, dataIn, progEn, protSel, serO, serOe_n, busy;
    wire serialLine;
    int miscompares = 0;
    int samplesChecked = 0;
    int busyCnt = 0;
    logic [16:0] rd;
    row_t rows [21];
    logic [7:0] rdAddr [7] = '{8'h05, 8'h20, 8'h3F, 8'h40, 8'h10, 8'h21, 8'h22};
    logic [15:0] rdExp [7] = '{16'hA5A5, 16'h2020, 16'h3F3F, 16'hA5A5, 16'hA5A5,
                               16'h1111, 16'hA5A5};
    // released output floats; no pull on this line
    assign serialLine = serOe_n ? 1'bz : serO;
    // clock and busy length counter
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (busy === 1'b1) busyCnt <= busyCnt + 1;
    eeprom_ctrl #(.PROG_CYC(PROG)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .chip_select(chipSel), .serial_clock(linkClk), .serial_in(dataIn),
        .serial_out_o(serO), .serial_out_oe_n(serOe_n), .program_enable_pin(progEn),
        .protect_select_pin(protSel), .busy(busy));
    link_master master (.chip_select(chipSel), .serial_clock(linkClk), .serial_in(dataIn),
        .program_enable_pin(progEn), .protect_select_pin(protSel), .serial_out(serialLine));
    // ordinary frames: pins, header, data, whether a timed cycle must start
    initial begin
        rows = '{'{1'b0, 1'b1, 11'h505, 1'b1, 16'h1234, 1'b0},
                 '{1'b0, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b0, 1'b1, 11'h440, 1'b1, 16'hA5A5, 1'b0},
                 '{1'b0, 1'b0, 11'h505, 1'b1, 16'h1234, 1'b0},
                 '{1'b1, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h7FF, 1'b0, 16'h0000, 1'b1},
                 '{1'b0, 1'b1, 11'h440, 1'b1, 16'hA5A5, 1'b1},
                 '{1'b1, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b0, 1'b1, 11'h520, 1'b1, 16'h2020, 1'b1},
                 '{1'b1, 1'b1, 11'h540, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h540, 1'b0, 16'h0000, 1'b1},
                 '{1'b0, 1'b1, 11'h540, 1'b1, 16'h4040, 1'b0},
                 '{1'b0, 1'b1, 11'h53F, 1'b1, 16'h3F3F, 1'b1},
                 '{1'b0, 1'b1, 11'h400, 1'b0, 16'h0000, 1'b0},
                 '{1'b0, 1'b1, 11'h510, 1'b1, 16'h1010, 1'b0},
                 '{1'b0, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h400, 1'b0, 16'h0000, 1'b1},
                 '{1'b1, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0},
                 '{1'b1, 1'b1, 11'h7FF, 1'b0, 16'h0000, 1'b0}};
    end
    task automatic testDone();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a cycle that never ends is a failure, not a hang
    task automatic waitIdle();
        for (int n = 0; n < 2 * PROG && busy !== 1'b0; n++) @(negedge sys_clk);
        if (busy !== 1'b0) begin
            miscompares++;
            testDone();
        end
    endtask
    task automatic runRow(input row_t r);
        logic seen;
        seen = 1'b0;
        busyCnt = 0;
        master.frame(r.pre, r.pe, r.hdr, r.hasData, r.data);
        for (int n = 0; n < 12 && !seen; n++) begin
            @(negedge sys_clk);
            seen = (busy === 1'b1);
        end
        chkBit(seen, r.start);
        master.select(1'b1);
        repeat (6) @(negedge sys_clk);
        if (r.start) begin
            chkBit(serOe_n, 1'b0);
            chkBit(serO, 1'b0);
            master.select(1'b0);
            repeat (6) @(negedge sys_clk);
            chkBit(serOe_n, 1'b1);
            master.select(1'b1);
            waitIdle();
            repeat (6) @(negedge sys_clk);
            chkBit(serO, 1'b1);
            chkVal(16'(busyCnt), 16'(PROG));
            master.shift(16'h0001, 1);
            repeat (6) @(negedge sys_clk);
            chkBit(serOe_n, 1'b1);
        end else chkBit(serOe_n | serO, 1'b1);
        master.select(1'b0);
        repeat (6) @(negedge sys_clk);
    endtask
    // reset, row loop, then the awkward cases
    initial begin
        repeat (20) @(negedge sys_clk);
        chkBit(serOe_n, 1'b1);
        chkBit(busy, 1'b0);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 21; i++) begin
            runRow(rows[i]);
            $display("row %0d done", i);
        end
        runRow('{1'b0, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0});
        master.frame(1'b0, 1'b1, 11'h521, 1'b1, 16'h1111);
        master.frame(1'b0, 1'b1, 11'h522, 1'b1, 16'h2222);
        waitIdle();
        repeat (20) @(negedge sys_clk);
        chkBit(busy, 1'b0);
        $display("frame during busy done");
        runRow('{1'b0, 1'b1, 11'h400, 1'b0, 16'h0000, 1'b0});
        for (int i = 0; i < 7; i++) begin
            master.read(1'b0, {3'h6, rdAddr[i]}, 16, rd);
            chkBit(rd[16], 1'b0);
            chkVal(rd[15:0], rdExp[i]);
        end
        master.read(1'b1, 11'h600, 8, rd);
        chkVal(rd[15:0], 16'h0040);
        $display("reads done");
        runRow('{1'b0, 1'b1, 11'h4C0, 1'b0, 16'h0000, 1'b0});
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        runRow('{1'b0, 1'b1, 11'h530, 1'b1, 16'h3030, 1'b0});
        $display("mid-run reset done");
        testDone();
    end
endmodule
